// *** logic/nvac_pkg.sv ***
// Package of constants for the data memory access controller
package nvac_pkg;
    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int NV_AW = 7;
    localparam int NV_DW = 8;
    localparam int NV_DEPTH = 128;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_UNLOCK = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int STAT_PWRT_BIT = 0;
    localparam int STAT_CP_BIT = 1;
    localparam int STAT_ARMED_BIT = 2;
    // ------------------------------------------------------------
    // Unlock keys, reset values and bus response codes
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [NV_AW-1:0] ADDR_RST = 7'h00;
    localparam logic [NV_DW-1:0] DATA_RST = 8'h00;
    localparam logic MASK_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int PWRT_MS = 72;
    localparam int PWRT_CYCLES = PWRT_MS * (1000000 / CLK_PERIOD_NS);
    localparam int WRITE_CYCLES_DEF = 2000;
    localparam int UNLOCK_GAP_MAX = 16;
    localparam int CNT_W = 24;
    // ------------------------------------------------------------
    // Unlock sequence states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_FIRST,
        UNL_ARMED
    } nvac_unlock_type;
endpackage : nvac_pkg

// *** logic/nvac_mem.sv ***
// Byte-wide data memory with registered read port
`timescale 1ns/10ps
module nvac_mem
    import nvac_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Write port
    input wire logic we,
    input wire logic [NV_AW-1:0] waddr,
    input wire logic [NV_DW-1:0] wdata,
    // Read port
    input wire logic [NV_AW-1:0] raddr,
    output logic [NV_DW-1:0] rdata_r
);
    logic [NV_DW-1:0] mem [0:NV_DEPTH-1];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        rdata_r <= mem[raddr];
    end
endmodule : nvac_mem

// *** logic/nvac_ctrl.sv ***
// Data memory access controller with AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module nvac_ctrl
    import nvac_pkg::*;
#(
    parameter int PWRT_CNT = PWRT_CYCLES,
    parameter int WRITE_CNT = WRITE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device pins and interrupt
    input wire logic code_protect,
    output logic irq
);
    // ------------------------------------------------------------
    // Register index decode
    // ------------------------------------------------------------
    localparam logic [2:0] IX_ADDR = 3'h0;
    localparam logic [2:0] IX_DATA = 3'h1;
    localparam logic [2:0] IX_CTRL = 3'h2;
    localparam logic [2:0] IX_UNLOCK = 3'h3;
    localparam logic [2:0] IX_STAT = 3'h4;
    localparam logic [2:0] IX_MASK = 3'h5;
    localparam logic [2:0] IX_STATUS = 3'h6;
    localparam logic [2:0] IX_NONE = 3'h7;

    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            OFS_ADDR: reg_index = IX_ADDR;
            OFS_DATA: reg_index = IX_DATA;
            OFS_CTRL: reg_index = IX_CTRL;
            OFS_UNLOCK: reg_index = IX_UNLOCK;
            OFS_IRQ_STAT: reg_index = IX_STAT;
            OFS_IRQ_MASK: reg_index = IX_MASK;
            OFS_STATUS: reg_index = IX_STATUS;
            default: reg_index = IX_NONE;
        endcase
    endfunction : reg_index
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_have_r;
    logic [7:0] aw_addr_r;
    logic w_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [NV_AW-1:0] addr_r;
    logic [NV_DW-1:0] data_r;
    logic write_enable_bit_r;
    logic wr_r;
    logic rd_pend_r;
    logic done_flag_r;
    logic done_flag_nxt;
    logic mask_r;
    logic [NV_AW-1:0] wa_r;
    logic [NV_DW-1:0] wd_r;
    logic [CNT_W-1:0] wcnt_r;
    logic [CNT_W-1:0] pwrt_r;
    logic [4:0] gap_r;
    nvac_unlock_type unl_r;
    nvac_unlock_type unl_nxt;
    logic cp_s1_r;
    logic cp_s2_r;
    logic cp_s3_r;
    logic cp_r;
    logic [NV_DW-1:0] mem_q;
    // ------------------------------------------------------------
    // Bus handshakes and decode
    // ------------------------------------------------------------
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
    wire [2:0] wix = reg_index(aw_addr_r);
    wire [2:0] rix = reg_index(s_axi_araddr);
    wire wr_hit = wr_go & w_strb_r[0] & (wix != IX_NONE);
    wire wr_addr_reg = wr_hit & (wix == IX_ADDR);
    wire wr_data_reg = wr_hit & (wix == IX_DATA);
    wire wr_ctrl = wr_hit & (wix == IX_CTRL);
    wire wr_unlock = wr_hit & (wix == IX_UNLOCK);
    wire wr_stat = wr_hit & (wix == IX_STAT);
    wire wr_mask = wr_hit & (wix == IX_MASK);
    wire [7:0] wbyte = w_data_r[7:0];

    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready = ~w_have_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    // ------------------------------------------------------------
    // Write start qualification
    // ------------------------------------------------------------
    wire pwrt_run = (pwrt_r != '0);
    wire gap_ok = (gap_r <= 5'(UNLOCK_GAP_MAX));
    wire set_wr = wr_ctrl & wbyte[CTRL_WR_BIT];
    wire armed = (unl_r == UNL_ARMED) & gap_ok;
    wire start_wr = set_wr & wbyte[CTRL_WRITE_ENABLE_BIT_BIT]
        & armed
        & ~pwrt_run
        & ~wr_r;
    wire wr_end = wr_r & (wcnt_r == CNT_W'(1));
    wire start_rd = wr_ctrl & wbyte[CTRL_RD_BIT];
    // ------------------------------------------------------------
    // Unlock sequence tracking
    // ------------------------------------------------------------
    always_comb begin
        unl_nxt = unl_r;
        case (unl_r)
            UNL_FIRST: begin
                if (!gap_ok) begin
                    unl_nxt = UNL_IDLE;
                end else if (wr_unlock && wbyte == KEY_SECOND) begin
                    unl_nxt = UNL_ARMED;
                end else if (wr_hit) begin
                    unl_nxt = UNL_IDLE;
                end
            end
            UNL_ARMED: begin
                if (!gap_ok || wr_hit) begin
                    unl_nxt = UNL_IDLE;
                end
            end
            default: unl_nxt = UNL_IDLE;
        endcase
        if (wr_unlock && wbyte == KEY_FIRST) begin
            unl_nxt = UNL_FIRST;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unl_r <= UNL_IDLE;
        end else begin
            unl_r <= unl_nxt;
        end
    end

    // Cycles since the last key write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_r <= '0;
        end else if (wr_unlock) begin
            gap_r <= '0;
        end else if (gap_r != 5'h1F) begin
            gap_r <= gap_r + 5'h01;
        end
    end
    // ------------------------------------------------------------
    // AXI write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (aw_take) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (w_take) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wix == IX_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------
    wire [31:0] ctrl_view = {29'h0, write_enable_bit_r, wr_r, 1'b0};
    wire [31:0] status_view = {29'h0, (unl_r == UNL_ARMED), cp_r,
        pwrt_run};
    wire [31:0] rmux =
        (rix == IX_ADDR) ? {25'h0, addr_r} :
        (rix == IX_DATA) ? {24'h0, data_r} :
        (rix == IX_CTRL) ? ctrl_view :
        (rix == IX_STAT) ? {31'h0, done_flag_r} :
        (rix == IX_MASK) ? {31'h0, mask_r} :
        (rix == IX_STATUS) ? status_view : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= (rix == IX_NONE) ? RESP_SLVERR : RESP_OKAY;
            rdata_r <= rmux;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Address, data and control registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= ADDR_RST;
        end else if (wr_addr_reg) begin
            addr_r <= wbyte[NV_AW-1:0];
        end
    end

    // Read result lands two cycles after the read bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= start_rd;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_r <= DATA_RST;
        end else if (rd_pend_r) begin
            data_r <= mem_q;
        end else if (wr_data_reg) begin
            data_r <= wbyte;
        end
    end

    // Only software changes write enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_enable_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            write_enable_bit_r <= wbyte[CTRL_WRITE_ENABLE_BIT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Write cycle engine
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_r <= 1'b0;
            wcnt_r <= '0;
            wa_r <= '0;
            wd_r <= '0;
        end else if (start_wr) begin
            wr_r <= 1'b1;
            wcnt_r <= CNT_W'(WRITE_CNT);
            wa_r <= addr_r;
            wd_r <= data_r;
        end else if (wr_end) begin
            wr_r <= 1'b0;
        end else if (wr_r) begin
            wcnt_r <= wcnt_r - CNT_W'(1);
        end
    end

    // Power-up timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwrt_r <= CNT_W'(PWRT_CNT);
        end else if (pwrt_run) begin
            pwrt_r <= pwrt_r - CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Completion flag and interrupt
    // ------------------------------------------------------------
    assign done_flag_nxt = (done_flag_r
        & ~(wr_stat & wbyte[IRQ_DONE_BIT])) | wr_end;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag_r <= 1'b0;
            mask_r <= MASK_RST;
        end else begin
            done_flag_r <= done_flag_nxt;
            if (wr_mask) begin
                mask_r <= wbyte[IRQ_DONE_BIT];
            end
        end
    end

    assign irq = done_flag_r & mask_r;

    // ------------------------------------------------------------
    // Code protect pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cp_s1_r <= 1'b0;
            cp_s2_r <= 1'b0;
            cp_s3_r <= 1'b0;
            cp_r <= 1'b0;
        end else begin
            cp_s1_r <= code_protect;
            cp_s2_r <= cp_s1_r;
            cp_s3_r <= cp_s2_r;
            if (cp_s2_r == cp_s3_r) begin
                cp_r <= cp_s3_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Memory array, contents stored plain regardless of protection
    // ------------------------------------------------------------
    nvac_mem u_mem (
        .aclk(aclk),
        .we(wr_end),
        .waddr(wa_r),
        .wdata(wd_r),
        .raddr(addr_r),
        .rdata_r(mem_q)
    );
endmodule : nvac_ctrl

// *** testbench/nvac_ctrl_sva.sv ***
// Assertion checker for the data memory access controller bus ports
`timescale 1ns/10ps
module nvac_ctrl_sva
    import nvac_pkg::*;
#(
    parameter int PWRT_CNT = PWRT_CYCLES,
    parameter int WRITE_CNT = WRITE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_wr_resp; s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("late bvalid");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("late rvalid");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp moved");
    property p_ar_rdy; s_axi_arready == !s_axi_rvalid; endproperty
    a_ar_rdy: assert property (p_ar_rdy) else $error("arready wrong");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("ready during bvalid");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_STATUS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_rst_idle;
        $rose(aresetn) |-> s_axi_awready && s_axi_arready && !irq;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("bad reset");
    property p_irq_keep; irq |=> irq || s_axi_bvalid; endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("irq fell");
    c_wr: cover property (s_wr_taken ##2 s_axi_bvalid);
    c_rd: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_irq: cover property ($rose(irq));
endmodule : nvac_ctrl_sva
bind nvac_ctrl nvac_ctrl_sva #(.PWRT_CNT(PWRT_CNT), .WRITE_CNT(WRITE_CNT))
    u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

// *** testbench/nvac_cpu_model.sv ***
// Bus master model of the CPU core issuing register accesses
`timescale 1ns/10ps
module nvac_cpu_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ka, kw, t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ka = awready;
            kw = wready;
            @(posedge aclk);
            if (ka) awvalid <= 1'b0;
            if (kw) wvalid <= 1'b0;
        end while (!((ka || !awvalid) && (kw || !wvalid)));
        do begin
            @(negedge aclk);
            t = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (!t);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end while (!t);
        rready <= 1'b0;
    endtask : rd
endmodule : nvac_cpu_model

// *** testbench/nvac_ctrl_tb.sv ***
// Self-checking testbench for the data memory access controller
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
module nvac_ctrl_tb
    import nvac_pkg::*;
;
    localparam logic [7:0] C_RD = 8'h01 << CTRL_RD_BIT;
    localparam logic [7:0] C_WR = 8'h01 << CTRL_WR_BIT;
    localparam logic [7:0] C_WE = 8'h01 << CTRL_WRITE_ENABLE_BIT_BIT;
    logic aclk, aresetn, code_protect, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    int error_cnt = 0;
    int num_checks = 0;
    // ------------------------------------------------------------
    // Clock, design and bus master
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    nvac_ctrl #(.PWRT_CNT(120), .WRITE_CNT(60)) dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .code_protect(code_protect), .irq(irq));
    nvac_cpu_model u_cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] rs;
        u_cpu.wr(a, {24'h000000, v}, rs);
        `CHK(rs, RESP_OKAY)
    endtask : w
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] rv;
        logic [1:0] rs;
        u_cpu.rd(a, rv, rs);
        `CHK(rv, {24'h000000, e})
    endtask : rchk
    task automatic unlock(input logic [7:0] c);
        w(OFS_UNLOCK, KEY_FIRST);
        w(OFS_UNLOCK, KEY_SECOND);
        w(OFS_CTRL, c);
    endtask : unlock
    task automatic poll(input logic [7:0] a, input int b);
        logic [31:0] rv;
        logic [1:0] rs;
        rv = 32'h00000001 << b;
        while (rv[b] !== 1'b0) u_cpu.rd(a, rv, rs);
    endtask : poll
    task automatic done_test(input string n);
        $display("test %s finished, errors so far %0d", n, error_cnt);
    endtask : done_test
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        code_protect = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(OFS_ADDR, 8'h00);
        rchk(OFS_DATA, 8'h00);
        rchk(OFS_CTRL, 8'h00);
        rchk(OFS_IRQ_MASK, 8'h00);
        rchk(OFS_STATUS, 8'h01 << STAT_PWRT_BIT);
        done_test("reset");
        w(OFS_CTRL, C_WE);
        unlock(C_WE | C_WR);
        rchk(OFS_CTRL, C_WE);
        poll(OFS_STATUS, STAT_PWRT_BIT);
        done_test("powerup");
        unlock(C_WR);
        rchk(OFS_CTRL, 8'h00);
        w(OFS_CTRL, C_WE);
        w(OFS_UNLOCK, KEY_SECOND);
        w(OFS_UNLOCK, KEY_FIRST);
        w(OFS_CTRL, C_WE | C_WR);
        rchk(OFS_CTRL, C_WE);
        w(OFS_UNLOCK, KEY_FIRST);
        w(OFS_UNLOCK, KEY_SECOND);
        repeat (40) @(posedge aclk);
        w(OFS_CTRL, C_WE | C_WR);
        rchk(OFS_CTRL, C_WE);
        done_test("refusals");
        // Interrupt masked around the sequence, then unmasked and cleared, write enable kept
        w(OFS_ADDR, 8'h05);
        w(OFS_DATA, 8'hA5);
        unlock(C_WE | C_WR);
        rchk(OFS_CTRL, C_WE | C_WR);
        poll(OFS_CTRL, CTRL_WR_BIT);
        rchk(OFS_CTRL, C_WE);
        rchk(OFS_IRQ_STAT, 8'h01);
        `CHK(irq, 1'b0)
        w(OFS_IRQ_MASK, 8'h01);
        `CHK(irq, 1'b1)
        rchk(OFS_IRQ_STAT, 8'h01);
        w(OFS_IRQ_STAT, 8'h01);
        `CHK(irq, 1'b0)
        rchk(OFS_IRQ_STAT, 8'h00);
        done_test("write");
        code_protect <= 1'b1;
        w(OFS_ADDR, 8'h06);
        w(OFS_DATA, 8'h5A);
        unlock(C_WE | C_WR);
        w(OFS_DATA, 8'h3C);
        w(OFS_CTRL, 8'h00);
        rchk(OFS_CTRL, C_WR);
        unlock(C_WE | C_WR);
        poll(OFS_CTRL, CTRL_WR_BIT);
        `CHK(irq, 1'b1)
        rchk(OFS_CTRL, C_WE);
        done_test("abort_try");
        w(OFS_ADDR, 8'h05);
        w(OFS_CTRL, C_RD);
        rchk(OFS_DATA, 8'hA5);
        w(OFS_ADDR, 8'h06);
        rchk(OFS_DATA, 8'hA5);
        w(OFS_CTRL, C_RD);
        rchk(OFS_DATA, 8'h5A);
        rchk(OFS_CTRL, 8'h00);
        rchk(OFS_STATUS, 8'h01 << STAT_CP_BIT);
        done_test("readback");
        u_cpu.rd(8'h40, d, r);
        `CHK(r, RESP_SLVERR)
        `CHK(d, 32'h00000000)
        u_cpu.wr(8'h40, 32'h000000FF, r);
        `CHK(r, RESP_SLVERR)
        done_test("unmapped");
        give_verdict();
    end
endmodule : nvac_ctrl_tb
